// ===== hdl/fsc_top.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_top #(
  parameter int NHARM       = 24,
  parameter int NSRC        = 16,
  parameter int TICK_CYCLES = `FSC_TICK_NS / `FSC_CLK_NS
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // register port
  input  wire fsc_pkg::fsc_bus_t    busIn,
  output logic [31:0]               busRdata,
  // system measurements, same clock
  input  wire logic                 preChargeDone,
  input  wire logic                 alarmCond,
  input  wire logic [6:0]           iLoadPct,
  input  wire logic [NHARM*7-1:0]   harmAmpPct,
  input  wire logic [NSRC-1:0]      statusSrc,
  input  wire logic                 isMaster,
  input  wire logic                 busStandby,
  // terminal pins
  input  wire logic                 userInputFirst,
  input  wire logic                 userInputSecond,
  input  wire logic                 userInputThird,
  // outputs
  output logic                      runCmd,
  output logic                      standbyOut,
  output logic                      secondarySet,
  output logic [NHARM-1:0]          harmRun,
  output logic                      alarmRelayClosed,
  output logic                      configurableRelayOutput
);
  import fsc_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TW-1:0]          tickCnt;
    logic [2:0]             sync1;
    logic [2:0]             sync2;
    logic [2:0]             lvlPrev;
    logic [1:0]             ssPend;
    fsc_cfg_t               cfg;
    logic [NHARM-1:0]       harmEn;
    logic [NSRC-1:0]        cfgSel;
    fsc_state_t             state;
    logic                   bootPend;
    logic [8:0]             bootTmr;
    logic [8:0]             stbyTmr;
    logic                   alarmLatch;
    logic [3:0]             restartCnt;
    logic                   hourRun;
    logic [11:0]            hourTmr;
    logic [8:0]             aMinTmr;
    logic [8:0]             cMinTmr;
    logic                   aAct;
    logic                   cAct;
    logic [NHARM-1:0][11:0] resTmr;
    logic [31:0]            rdata;
  } fsc_st_t;

  localparam fsc_cfg_t CFG_DEF = '{
    autoSel:     3'h0,
    autoRestart: 1'b0,
    stbyEn:      1'b0,
    wakePct:     `FSC_DEF_WAKE,
    sleepPct:    `FSC_DEF_SLEEP,
    wakeDly:     `FSC_DEF_WDLY,
    sleepDly:    `FSC_DEF_SDLY,
    resLim:      `FSC_DEF_RES,
    alarmMin:    `FSC_ALARM_MIN,
    alarmNc:     1'b0,
    cfgNc:       1'b0,
    inCfg:       12'h000
  };

  fsc_st_t          q;
  fsc_st_t          d;
  logic [NHARM-1:0] resOver;
  logic             secSet;

  // ----------------------------------------
  // per-harmonic resonance compare
  // ----------------------------------------
  for (genvar g = 0; g < NHARM; g++)
  begin : g_res
    assign resOver[g] = harmAmpPct[g*7 +: 7] > q.cfg.resLim;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic            tick;
    logic [2:0]      lvl;
    logic [2:0]      act;
    logic            startCmd;
    logic            stopCmd;
    logic            ackCmd;
    logic            extAlarm;
    logic            alarmNow;
    logic            low;
    logic            high;
    logic [13:0]     lhs;
    logic [13:0]     rhs;
    logic [8:0]      bootDly;
    logic [6:0]      w7;
    logic [8:0]      w9;
    fsc_func_t       fn;
    d        = q;
    tick     = 1'b0;
    lvl      = q.sync2;
    act      = 3'h0;
    startCmd = 1'b0;
    stopCmd  = 1'b0;
    ackCmd   = 1'b0;
    extAlarm = 1'b0;
    secSet   = 1'b0;
    w7       = 7'h00;
    w9       = 9'h000;
    fn       = FSC_F_NONE;
    alarmNow = 1'b0;
    // standby level compare
    lhs  = 14'(iLoadPct) * 14'd100;
    rhs  = 14'(q.cfg.wakePct) * 14'(q.cfg.sleepPct);
    low  = lhs < rhs;
    high = iLoadPct > q.cfg.wakePct;
    bootDly = (q.cfg.autoSel > 3'h1) ? 9'(q.cfg.autoSel - 3'h1) * `FSC_STEP_S : 9'h000;
    // one second tick
    if (q.tickCnt == TW'(TICK_CYCLES - 1))
    begin
      d.tickCnt = '0;
      tick      = 1'b1;
    end
    else
      d.tickCnt = q.tickCnt + TW'(1);
    // pin synchronisers
    d.sync1 = {userInputThird, userInputSecond, userInputFirst};
    d.sync2 = q.sync1;
    d.lvlPrev = lvl;
    // input functions
    for (int i = 0; i < 3; i++)
    begin
      act[i] = lvl[i] ~^ q.cfg.inCfg[i][3];
      fn     = fsc_func_t'(q.cfg.inCfg[i][2:0]);
      case (fn)
        FSC_F_ALARM: extAlarm = extAlarm | act[i];
        FSC_F_START: startCmd = startCmd | (act[i] & ~(q.lvlPrev[i] ~^ q.cfg.inCfg[i][3]));
        FSC_F_STOP:  stopCmd  = stopCmd | (act[i] & ~(q.lvlPrev[i] ~^ q.cfg.inCfg[i][3]));
        FSC_F_ACK:   ackCmd   = ackCmd | act[i];
        FSC_F_SEC:   secSet   = secSet | act[i];
        FSC_F_SS:
        begin
          if (lvl[i] != q.lvlPrev[i])
            d.ssPend = act[i] ? 2'b01 : 2'b10;
        end
        default: ;
      endcase
    end
    startCmd = startCmd | q.ssPend[0];
    stopCmd  = stopCmd | q.ssPend[1];
    // software commands
    if (busIn.wr && busIn.addr == `FSC_REG_CTRL)
    begin
      startCmd = startCmd | busIn.wdata[`FSC_CTRL_START];
      stopCmd  = stopCmd | busIn.wdata[`FSC_CTRL_STOP];
      ackCmd   = ackCmd | busIn.wdata[`FSC_CTRL_ACK];
    end
    alarmNow = alarmCond | extAlarm;
    // restart window
    if (q.hourRun && tick)
    begin
      if (q.hourTmr == `FSC_HOUR_S - 12'h001)
      begin
        d.hourRun    = 1'b0;
        d.restartCnt = 4'h0;
      end
      else
        d.hourTmr = q.hourTmr + 12'h001;
    end
    if (ackCmd)
      d.restartCnt = 4'h0;
    // state machine
    case (q.state)
      FSC_STOP:
      begin
        if (startCmd)
          d.state = FSC_RUN;
        else if (q.bootPend && preChargeDone)
        begin
          if (q.cfg.autoSel == 3'h0)
            d.bootPend = 1'b0;
          else if (q.bootTmr >= bootDly)
          begin
            d.bootPend = 1'b0;
            d.state    = FSC_RUN;
          end
          else if (tick)
            d.bootTmr = q.bootTmr + 9'h001;
        end
      end
      FSC_RUN:
      begin
        if (stopCmd)
          d.state = FSC_STOP;
        else if (q.cfg.stbyEn && !isMaster)
        begin
          if (busStandby)
            d.state = FSC_STBY;
        end
        else if (q.cfg.stbyEn && low)
        begin
          if (q.stbyTmr >= q.cfg.sleepDly)
            d.state = FSC_STBY;
          else if (tick)
            d.stbyTmr = q.stbyTmr + 9'h001;
        end
        else
          d.stbyTmr = 9'h000;
      end
      FSC_STBY:
      begin
        if (stopCmd)
          d.state = FSC_STOP;
        else if (!q.cfg.stbyEn)
          d.state = FSC_RUN;
        else if (!isMaster)
        begin
          if (!busStandby)
            d.state = FSC_RUN;
        end
        else if (high)
        begin
          if (q.stbyTmr >= q.cfg.wakeDly)
            d.state = FSC_RUN;
          else if (tick)
            d.stbyTmr = q.stbyTmr + 9'h001;
        end
        else
          d.stbyTmr = 9'h000;
      end
      FSC_ALARM:
      begin
        if (!alarmNow && ackCmd)
        begin
          d.alarmLatch = 1'b0;
          d.state      = FSC_STOP;
        end
        else if (!alarmNow && q.cfg.autoRestart && q.restartCnt < `FSC_RESTART_MAX)
        begin
          d.alarmLatch = 1'b0;
          d.restartCnt = q.restartCnt + 4'h1;
          d.state      = FSC_RUN;
          if (!q.hourRun)
          begin
            d.hourRun = 1'b1;
            d.hourTmr = 12'h000;
          end
        end
      end
      default: d.state = FSC_STOP;
    endcase
    if (d.state != q.state)
      d.stbyTmr = 9'h000;
    if (q.ssPend[0] && (q.state == FSC_RUN || q.state == FSC_STBY))
      d.ssPend = 2'b00;
    if (q.ssPend[1] && q.state == FSC_STOP)
      d.ssPend = 2'b00;
    // alarm entry wins over any clear
    if (alarmNow)
    begin
      d.alarmLatch = 1'b1;
      d.state      = FSC_ALARM;
      d.bootPend   = 1'b0;
    end
    // alarm relay with minimum on time
    if (alarmNow && !q.alarmLatch)
      d.aMinTmr = 9'(q.cfg.alarmMin) + 9'h001;
    else if (tick && q.aMinTmr != 9'h000)
      d.aMinTmr = q.aMinTmr - 9'h001;
    d.aAct = d.alarmLatch | (d.aMinTmr != 9'h000);
    // configurable relay
    if ((|(statusSrc & q.cfgSel)) && !q.cAct)
      d.cMinTmr = `FSC_CFG_MIN_S + 9'h001;
    else if (tick && q.cMinTmr != 9'h000)
      d.cMinTmr = q.cMinTmr - 9'h001;
    d.cAct = (|(statusSrc & q.cfgSel)) | (d.cMinTmr != 9'h000);
    // resonance hold-off
    for (int h = 0; h < NHARM; h++)
    begin
      if (q.resTmr[h] == 12'h000)
      begin
        if (q.harmEn[h] && resOver[h])
          d.resTmr[h] = `FSC_HOUR_S;
      end
      else if (tick)
        d.resTmr[h] = q.resTmr[h] - 12'h001;
    end
    // register writes with range clamps
    if (busIn.wr)
    begin
      case (busIn.addr)
        `FSC_REG_CTRL:
        begin
          if (busIn.wdata[`FSC_CTRL_DEFAULT])
          begin
            d.cfg    = CFG_DEF;
            d.harmEn = '0;
            d.cfgSel = '0;
          end
        end
        `FSC_REG_AUTO:
        begin
          d.cfg.autoSel     = busIn.wdata[2:0];
          d.cfg.autoRestart = busIn.wdata[3];
          d.cfg.stbyEn      = busIn.wdata[4];
        end
        `FSC_REG_STBY:
        begin
          w7 = busIn.wdata[6:0];
          d.cfg.wakePct = (w7 > `FSC_PCT_MAX) ? `FSC_PCT_MAX : w7;
          w7 = busIn.wdata[13:7];
          d.cfg.sleepPct = (w7 > `FSC_SLEEP_MAX) ? `FSC_SLEEP_MAX : w7;
        end
        `FSC_REG_DELAY:
        begin
          w9 = busIn.wdata[8:0];
          d.cfg.wakeDly = (w9 > `FSC_DLY_MAX) ? `FSC_DLY_MAX : w9;
          w9 = busIn.wdata[24:16];
          d.cfg.sleepDly = (w9 > `FSC_DLY_MAX) ? `FSC_DLY_MAX :
                           (w9 < `FSC_SLEEP_MIN) ? `FSC_SLEEP_MIN : w9;
        end
        `FSC_REG_RESLIM:
        begin
          w7 = busIn.wdata[6:0];
          d.cfg.resLim = (w7 > `FSC_PCT_MAX) ? `FSC_PCT_MAX :
                         (w7 < `FSC_RES_MIN) ? `FSC_RES_MIN : w7;
        end
        `FSC_REG_HARMEN: d.harmEn = busIn.wdata[NHARM-1:0];
        `FSC_REG_RELAY:
        begin
          d.cfg.alarmMin = (busIn.wdata[7:0] == 8'h00) ? `FSC_ALARM_MIN : busIn.wdata[7:0];
          d.cfg.alarmNc  = busIn.wdata[8];
          d.cfg.cfgNc    = busIn.wdata[9];
        end
        `FSC_REG_CFGSEL: d.cfgSel = busIn.wdata[NSRC-1:0];
        `FSC_REG_INCFG:  d.cfg.inCfg = busIn.wdata[11:0];
        default: ;
      endcase
    end
    // register reads, data in next cycle only
    d.rdata = 32'h0000_0000;
    if (busIn.rd)
    begin
      case (busIn.addr)
        `FSC_REG_AUTO:
          d.rdata = {27'h0, q.cfg.stbyEn, q.cfg.autoRestart, q.cfg.autoSel};
        `FSC_REG_STBY:   d.rdata = {18'h0, q.cfg.sleepPct, q.cfg.wakePct};
        `FSC_REG_DELAY:  d.rdata = {7'h0, q.cfg.sleepDly, 7'h0, q.cfg.wakeDly};
        `FSC_REG_RESLIM: d.rdata = {25'h0, q.cfg.resLim};
        `FSC_REG_HARMEN: d.rdata = 32'(q.harmEn);
        `FSC_REG_RELAY:
          d.rdata = {22'h0, q.cfg.cfgNc, q.cfg.alarmNc, q.cfg.alarmMin};
        `FSC_REG_CFGSEL: d.rdata = 32'(q.cfgSel);
        `FSC_REG_INCFG:  d.rdata = {20'h0, q.cfg.inCfg};
        `FSC_REG_STATUS:
          d.rdata = {18'h0, (q.state == FSC_STBY), secondarySet, q.restartCnt,
                     q.alarmLatch, q.sync2, configurableRelayOutput,
                     alarmRelayClosed, q.state};
        `FSC_REG_HARMRUN: d.rdata = 32'(harmRun);
        `FSC_REG_ILOAD:   d.rdata = {25'h0, iLoadPct};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q          <= '0;
      q.cfg      <= CFG_DEF;
      q.bootPend <= 1'b1;
    end
    else
      q <= d;
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      runCmd                  <= 1'b0;
      standbyOut              <= 1'b0;
      secondarySet            <= 1'b0;
      harmRun                 <= '0;
      alarmRelayClosed        <= 1'b0;
      configurableRelayOutput <= 1'b0;
      busRdata                <= 32'h0000_0000;
    end
    else
    begin
      runCmd                  <= d.state == FSC_RUN;
      standbyOut              <= d.state == FSC_STBY;
      secondarySet            <= secSet;
      for (int h = 0; h < NHARM; h++)
        harmRun[h] <= q.harmEn[h] && d.resTmr[h] == 12'h000;
      alarmRelayClosed        <= d.aAct ^ q.cfg.alarmNc;
      configurableRelayOutput <= d.cAct ^ q.cfg.cfgNc;
      busRdata                <= d.rdata;
    end
  end
endmodule : fsc_top

// ===== hdl/fsc_consts.svh
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define FSC_REG_CTRL    4'h0
`define FSC_REG_AUTO    4'h1
`define FSC_REG_STBY    4'h2
`define FSC_REG_DELAY   4'h3
`define FSC_REG_RESLIM  4'h4
`define FSC_REG_HARMEN  4'h5
`define FSC_REG_RELAY   4'h6
`define FSC_REG_CFGSEL  4'h7
`define FSC_REG_INCFG   4'h8
`define FSC_REG_STATUS  4'h9
`define FSC_REG_HARMRUN 4'hA
`define FSC_REG_ILOAD   4'hB
// ----------------------------------------
// control bits
// ----------------------------------------
`define FSC_CTRL_START   0
`define FSC_CTRL_STOP    1
`define FSC_CTRL_ACK     2
`define FSC_CTRL_DEFAULT 3
// ----------------------------------------
// limits and defaults
// ----------------------------------------
`define FSC_PCT_MAX     7'h64
`define FSC_SLEEP_MAX   7'h5F
`define FSC_RES_MIN     7'h01
`define FSC_DLY_MAX     9'h12C
`define FSC_SLEEP_MIN   9'h005
`define FSC_STEP_S      9'h00A
`define FSC_ALARM_MIN   8'h01
`define FSC_RESTART_MAX 4'hA
`define FSC_HOUR_S      12'hE10
`define FSC_CFG_MIN_S   9'h001
`define FSC_DEF_WAKE    7'h14
`define FSC_DEF_SLEEP   7'h55
`define FSC_DEF_WDLY    9'h000
`define FSC_DEF_SDLY    9'h005
`define FSC_DEF_RES     7'h0A
// ----------------------------------------
// timing
// ----------------------------------------
`define FSC_CLK_NS      10
`define FSC_TICK_NS     1000000000
`endif

// ===== hdl/fsc_pkg.sv
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_STOP  = 2'b00,
    FSC_RUN   = 2'b01,
    FSC_STBY  = 2'b10,
    FSC_ALARM = 2'b11
  } fsc_state_t;
  typedef enum logic [2:0] {
    FSC_F_NONE  = 3'b000,
    FSC_F_ALARM = 3'b001,
    FSC_F_START = 3'b010,
    FSC_F_STOP  = 3'b011,
    FSC_F_ACK   = 3'b100,
    FSC_F_SEC   = 3'b101,
    FSC_F_SS    = 3'b110
  } fsc_func_t;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fsc_bus_t;
  typedef struct packed {
    logic [2:0]       autoSel;
    logic             autoRestart;
    logic             stbyEn;
    logic [6:0]       wakePct;
    logic [6:0]       sleepPct;
    logic [8:0]       wakeDly;
    logic [8:0]       sleepDly;
    logic [6:0]       resLim;
    logic [7:0]       alarmMin;
    logic             alarmNc;
    logic             cfgNc;
    logic [2:0][3:0]  inCfg;
  } fsc_cfg_t;
endpackage : fsc_pkg

// ===== tb/fsc_top_chk.sv
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_top_chk #(
  parameter int NHARM       = 24,
  parameter int NSRC        = 16,
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic               mclk,
  input wire logic               sys_rst,
  // register port
  input wire fsc_pkg::fsc_bus_t  busIn,
  input wire logic [31:0]        busRdata,
  // causes
  input wire logic               alarmCond,
  input wire logic [NHARM*7-1:0] harmAmpPct,
  input wire logic [NSRC-1:0]    statusSrc,
  // outputs
  input wire logic               runCmd,
  input wire logic               standbyOut,
  input wire logic [NHARM-1:0]   harmRun,
  input wire logic               alarmRelayClosed,
  input wire logic               configurableRelayOutput
);
  import fsc_pkg::*;
  // ----------------------------------------
  // shadow of settings written over the bus
  // ----------------------------------------
  logic [NSRC-1:0] selQ;
  logic [6:0]      resLimQ;
  logic            cfgNcQ;
  logic            cfgNcP;
  logic            almNcQ;
  logic            almNcP;
  logic [31:0]     onCnt;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      selQ    <= '0;
      resLimQ <= `FSC_DEF_RES;
      cfgNcQ  <= 1'b0;
      cfgNcP  <= 1'b0;
      almNcQ  <= 1'b0;
      almNcP  <= 1'b0;
      onCnt   <= '0;
    end
    else
    begin
      cfgNcP <= cfgNcQ;
      almNcP <= almNcQ;
      // cycles the configurable contact has been in its active position
      onCnt  <= (configurableRelayOutput ^ cfgNcP) ? onCnt + 32'h1 : 32'h0;
      if (busIn.wr && busIn.addr == `FSC_REG_CTRL && busIn.wdata[`FSC_CTRL_DEFAULT])
      begin
        selQ    <= '0;
        resLimQ <= `FSC_DEF_RES;
        cfgNcQ  <= 1'b0;
        almNcQ  <= 1'b0;
      end
      else if (busIn.wr && busIn.addr == `FSC_REG_RELAY)
      begin
        cfgNcQ <= busIn.wdata[9];
        almNcQ <= busIn.wdata[8];
      end
      else if (busIn.wr && busIn.addr == `FSC_REG_CFGSEL)
        selQ <= busIn.wdata[NSRC-1:0];
      else if (busIn.wr && busIn.addr == `FSC_REG_RESLIM)
        resLimQ <= (busIn.wdata[6:0] < `FSC_RES_MIN) ? `FSC_RES_MIN :
                   (busIn.wdata[6:0] > `FSC_PCT_MAX) ? `FSC_PCT_MAX : busIn.wdata[6:0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(busIn.rd) |-> busRdata == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(busIn.rd) && $past(busIn.addr) > `FSC_REG_ILOAD
    |-> busRdata == 32'h0) else $error("unmapped read not zero");
  a_reset_open: assert property (disable iff (1'b0) sys_rst |->
    !alarmRelayClosed && !configurableRelayOutput && !runCmd)
    else $error("contact closed in reset");
  a_run_excl: assert property (!(runCmd && standbyOut))
    else $error("run and standby together");
  a_stop_halts: assert property (busIn.wr && busIn.addr == `FSC_REG_CTRL &&
    busIn.wdata[`FSC_CTRL_STOP] |-> ##[1:2] !runCmd) else $error("stop command ignored");
  a_alarm_halts: assert property (alarmCond |-> ##[1:2] (!runCmd && !standbyOut))
    else $error("alarm did not stop operation");
  a_alarm_relay: assert property (alarmCond |-> ##[1:2] (alarmRelayClosed ^ almNcP))
    else $error("alarm contact not active");
  a_cfg_follow: assert property (|(statusSrc & selQ) |=>
    (configurableRelayOutput ^ cfgNcP)) else $error("cfg contact not active");
  a_cfg_min_on: assert property (!(configurableRelayOutput ^ cfgNcP) && onCnt != 32'h0
    |-> onCnt >= TICK_CYCLES - 1) else $error("cfg contact released too early");
  a_res_stop: assert property (runCmd && harmRun[0] && harmAmpPct[6:0] > resLimQ
    |-> ##[1:2] !harmRun[0]) else $error("resonant harmonic kept running");
endmodule : fsc_top_chk

bind fsc_top fsc_top_chk #(.NHARM(NHARM), .NSRC(NSRC), .TICK_CYCLES(TICK_CYCLES)) uChk (
  .mclk(mclk), .sys_rst(sys_rst), .busIn(busIn), .busRdata(busRdata), .alarmCond(alarmCond),
  .harmAmpPct(harmAmpPct), .statusSrc(statusSrc), .runCmd(runCmd), .standbyOut(standbyOut),
  .harmRun(harmRun), .alarmRelayClosed(alarmRelayClosed),
  .configurableRelayOutput(configurableRelayOutput));

// ===== tb/fsc_ext_equip.sv
`timescale 1ns/1ps
module fsc_ext_equip (
  // clock and requested pin levels
  input wire logic  mclk,
  input wire logic  [2:0] pinReq,
  // terminal pins
  output logic      userInputFirst,
  output logic      userInputSecond,
  output logic      userInputThird,
  // relay contacts
  input wire logic  configurableRelayOutput,
  output int        closures
);
  logic [2:0] pins = 3'h0;
  // switches move just after an edge, like a slow contact
  always @(posedge mclk) pins <= pinReq;
  assign userInputFirst  = pins[0];
  assign userInputSecond = pins[1];
  assign userInputThird  = pins[2];
  initial closures = 0;
  always @(posedge configurableRelayOutput) closures = closures + 1;
endmodule : fsc_ext_equip

// ===== tb/test_filter_supervisory_control.sv
`timescale 1ns/1ps
`include "fsc_consts.svh"
module test_filter_supervisory_control;
  import fsc_pkg::*;
  localparam int TK = 10;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic mclk, sys_rst, preChargeDone, alarmCond, isMaster, busStandby;
  logic in1, in2, in3, runCmd, standbyOut, secondarySet, almRly, cfgRly;
  fsc_bus_t    busIn;
  logic [31:0] busRdata;
  logic [6:0]  iLoadPct;
  logic [13:0] harmAmpPct;
  logic [3:0]  statusSrc;
  logic [1:0]  harmRun;
  logic [2:0]  pinReq;
  int closures, miscompares = 0, checks = 0, cycles = 0;
  fsc_top #(.NHARM(2), .NSRC(4), .TICK_CYCLES(TK)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .busIn(busIn), .busRdata(busRdata), .preChargeDone(preChargeDone), .alarmCond(alarmCond),
    .iLoadPct(iLoadPct), .harmAmpPct(harmAmpPct), .statusSrc(statusSrc), .isMaster(isMaster),
    .busStandby(busStandby), .userInputFirst(in1), .userInputSecond(in2),
    .userInputThird(in3), .runCmd(runCmd), .standbyOut(standbyOut),
    .secondarySet(secondarySet), .harmRun(harmRun), .alarmRelayClosed(almRly),
    .configurableRelayOutput(cfgRly));
  fsc_ext_equip uEquip (.mclk(mclk), .pinReq(pinReq), .userInputFirst(in1),
    .userInputSecond(in2), .userInputThird(in3), .configurableRelayOutput(cfgRly),
    .closures(closures));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    busIn <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busIn.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, string nm);
    @(posedge mclk);
    busIn <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busIn.rd <= 1'b0;
    #1;
    chk(nm, e, busRdata & m);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic pin(input logic [2:0] v);
    @(posedge mclk) pinReq <= v;
    cyc(8);
  endtask : pin
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {sys_rst, busIn, preChargeDone, alarmCond, harmAmpPct, statusSrc, busStandby} = '0;
    sys_rst = 1'b1;
    isMaster = 1'b1;
    iLoadPct = 7'h3C;
    pinReq = 3'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    wr(`FSC_REG_AUTO, 32'h2);
    @(posedge mclk) preChargeDone <= 1'b1;
    cyc(9 * TK);
    chk("autostart early", 0, runCmd);
    cyc(3 * TK);
    chk("autostart run", 1, runCmd);
    $display("test autostart done");
    wr(`FSC_REG_STBY, 32'h3FFF);
    rd(`FSC_REG_STBY, ALL, 32'h2FE4, "level clamp");
    wr(`FSC_REG_DELAY, 32'h01FF01FF);
    rd(`FSC_REG_DELAY, ALL, 32'h012C012C, "delay clamp high");
    wr(`FSC_REG_DELAY, 32'h0);
    rd(`FSC_REG_DELAY, ALL, 32'h00050000, "delay clamp low");
    wr(`FSC_REG_RESLIM, 32'h0);
    rd(`FSC_REG_RESLIM, ALL, 32'h1, "limit clamp low");
    wr(`FSC_REG_RESLIM, 32'h7F);
    rd(`FSC_REG_RESLIM, ALL, 32'h64, "limit clamp high");
    wr(`FSC_REG_RELAY, 32'h0);
    rd(`FSC_REG_RELAY, 32'hFF, 32'h1, "min time clamp");
    rd(4'hF, ALL, 32'h0, "unmapped");
    wr(`FSC_REG_CTRL, 32'h8);
    rd(`FSC_REG_STBY, ALL, 32'h2A94, "default levels");
    rd(`FSC_REG_DELAY, ALL, 32'h00050000, "default delays");
    rd(`FSC_REG_RESLIM, ALL, 32'hA, "default limit");
    rd(`FSC_REG_AUTO, ALL, 32'h0, "default auto");
    $display("test settings done");
    @(posedge mclk) alarmCond <= 1'b1;
    cyc(3);
    chk("alarm contact", 1, almRly);
    @(posedge mclk) alarmCond <= 1'b0;
    cyc(3 * TK);
    chk("alarm contact held", 1, almRly);
    chk("no restart", 0, runCmd);
    wr(`FSC_REG_CTRL, 32'h4);
    cyc(3 * TK);
    chk("alarm contact freed", 0, almRly);
    wr(`FSC_REG_AUTO, 32'h8);
    wr(`FSC_REG_CTRL, 32'h1);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge mclk) alarmCond <= 1'b1;
      cyc(2);
      @(posedge mclk) alarmCond <= 1'b0;
      cyc(6);
      chk("auto restart", (i < 10), runCmd);
    end
    rd(`FSC_REG_STATUS, 32'hF03, 32'hA03, "restart count");
    wr(`FSC_REG_CTRL, 32'h4);
    rd(`FSC_REG_STATUS, 32'hF03, 32'h0, "count after ack");
    $display("test alarm done");
    wr(`FSC_REG_AUTO, 32'h10);
    wr(`FSC_REG_STBY, 32'h1932);
    wr(`FSC_REG_DELAY, 32'h00050002);
    wr(`FSC_REG_CTRL, 32'h1);
    @(posedge mclk) iLoadPct <= 7'h19;
    cyc(7 * TK);
    chk("sleep edge level", 1, runCmd);
    @(posedge mclk) iLoadPct <= 7'h0A;
    cyc(4 * TK);
    chk("sleep early", 1, runCmd);
    cyc(3 * TK);
    chk("sleep", 1, standbyOut);
    @(posedge mclk) iLoadPct <= 7'h32;
    cyc(4 * TK);
    chk("wake edge level", 1, standbyOut);
    @(posedge mclk) iLoadPct <= 7'h3C;
    cyc(TK);
    chk("wake early", 1, standbyOut);
    cyc(3 * TK);
    chk("wake", 1, runCmd);
    @(posedge mclk) isMaster <= 1'b0;
    busStandby <= 1'b1;
    cyc(4);
    chk("slave standby", 1, standbyOut);
    @(posedge mclk) busStandby <= 1'b0;
    iLoadPct <= 7'h0A;
    cyc(8 * TK);
    chk("slave run", 1, runCmd);
    @(posedge mclk) isMaster <= 1'b1;
    iLoadPct <= 7'h3C;
    wr(`FSC_REG_AUTO, 32'h0);
    wr(`FSC_REG_CTRL, 32'h2);
    $display("test standby done");
    wr(`FSC_REG_CFGSEL, 32'h2);
    @(posedge mclk) statusSrc <= 4'h1;
    cyc(5);
    chk("unselected source", 0, cfgRly);
    @(posedge mclk) statusSrc <= 4'h2;
    @(posedge mclk) statusSrc <= 4'h0;
    cyc(TK / 2);
    chk("pulse stretched", 1, cfgRly);
    cyc(3 * TK);
    chk("cfg contact freed", 0, cfgRly);
    chk("one closure", 1, closures);
    rd(`FSC_REG_STATUS, 32'hC, 32'h0, "contacts open");
    wr(`FSC_REG_RELAY, 32'h301);
    rd(`FSC_REG_STATUS, 32'hC, 32'hC, "nc contacts closed");
    wr(`FSC_REG_RELAY, 32'h001);
    $display("test relays done");
    wr(`FSC_REG_INCFG, 32'h95E);
    cyc(8);
    chk("secondary low active", 1, secondarySet);
    pin(3'b011);
    chk("secondary off", 0, secondarySet);
    chk("combined start", 1, runCmd);
    rd(`FSC_REG_STATUS, 32'h70, 32'h30, "input levels");
    wr(`FSC_REG_CTRL, 32'h2);
    cyc(3 * TK);
    chk("combined silent", 0, runCmd);
    wr(`FSC_REG_CTRL, 32'h1);
    pin(3'b010);
    chk("combined stop", 0, runCmd);
    pin(3'b110);
    chk("input alarm", 1, almRly);
    pin(3'b010);
    wr(`FSC_REG_INCFG, 32'h54C);
    pin(3'b011);
    cyc(22);
    chk("input ack", 0, almRly);
    wr(`FSC_REG_INCFG, 32'h54A);
    pin(3'b010);
    pin(3'b011);
    chk("input start", 1, runCmd);
    wr(`FSC_REG_INCFG, 32'h54B);
    pin(3'b010);
    pin(3'b011);
    chk("input stop", 0, runCmd);
    $display("test inputs done");
    wr(`FSC_REG_HARMEN, 32'h3);
    wr(`FSC_REG_CTRL, 32'h1);
    cyc(3);
    chk("harmonics run", 32'h3, harmRun);
    @(posedge mclk) harmAmpPct <= {7'h0A, 7'h14};
    cyc(4);
    chk("resonance hold", 32'h2, harmRun);
    @(posedge mclk) harmAmpPct <= '0;
    cyc(3590 * TK);
    chk("hold before hour", 32'h2, harmRun);
    cyc(20 * TK);
    chk("rerun after hour", 32'h3, harmRun);
    $display("test resonance done");
    wrap_up();
  end
endmodule : test_filter_supervisory_control
